// ==== pkg/slo_pkg.sv ====
// constants and types shared by both ends of the serial low-side output link
//
// ====================================================================
package slo_pkg;

    // ================================================================
    // frame
    localparam int FRAME_BITS = 8;

    localparam logic [7:0] CTRL_RESET = 8'h00;

    // ================================================================
    // timing
    localparam int REF_CLK_NS       = 8;
    localparam int RESET_DELAY_MS   = 6;
    localparam int DEGLITCH_US      = 40;
    localparam int SYNC_FILTER_US   = 20;
    localparam int RESET_DELAY_CYC  =
        (RESET_DELAY_MS * 1000000 + REF_CLK_NS - 1) / REF_CLK_NS;
    localparam int DEGLITCH_CYC     =
        (DEGLITCH_US * 1000 + REF_CLK_NS - 1) / REF_CLK_NS;
    localparam int SYNC_FILTER_CYC  =
        (SYNC_FILTER_US * 1000 + REF_CLK_NS - 1) / REF_CLK_NS;
    localparam int SCLK_HALF_CYC    = 4;
    localparam int FRAME_GAP_CYC    = 16;

    // ================================================================
    // states
    typedef enum logic [1:0] {
        SLO_SUP_HOLD,
        SLO_SUP_RUN
    } slo_sup_t;

    typedef enum logic [1:0] {
        SLO_HOST_IDLE,
        SLO_HOST_LOW,
        SLO_HOST_HIGH,
        SLO_HOST_GAP
    } slo_host_t;

endpackage : slo_pkg

// ==== pkg/slo_link_if.sv ====
// serial link between host and output device, with open-drain reset wire
`timescale 1ns/100ps

interface slo_link_if;
    logic csN;
    logic sclk;
    logic mosi;
    logic rstOe;
    logic hostRstOe;
    wire  rstN;

    // ================================================================
    // open-drain wire with pull-up
    assign rstN = ~(rstOe | hostRstOe);

    modport device (
        input  csN,
        input  sclk,
        input  mosi,
        input  rstN,
        output rstOe
    );

    modport host (
        output csN,
        output sclk,
        output mosi,
        output hostRstOe,
        input  rstN
    );
endinterface : slo_link_if

// ==== hw/slo_device.sv ====
// output device end: serial shift, control register, reset supervisor, sync filter
`timescale 1ns/100ps

module slo_device
    import slo_pkg::*;
#(
    parameter int WIDTH           = FRAME_BITS,
    parameter int RESET_DELAY     = RESET_DELAY_CYC,
    parameter int DEGLITCH        = DEGLITCH_CYC,
    parameter int SYNC_FILTER     = SYNC_FILTER_CYC
) (
    input  wire logic             ref_clk,
    input  wire logic             arst_n,
    slo_link_if.device            link,
    input  wire logic             supplyGood,
    input  wire logic             firstDriverForceOn,
    input  wire logic             mainsSenseIn,
    output logic [WIDTH-1:0]      lowSideDrivers,
    output logic                  zeroCrossSyncOut
);

    // ================================================================
    // link domain state
    typedef struct packed {
        logic [WIDTH-1:0] shift;
        logic [3:0]       bitCnt;
    } slo_link_state_t;

    slo_link_state_t lnk;
    slo_link_state_t next_lnk;

    // ================================================================
    // reference domain state
    typedef struct packed {
        logic             supS1;
        logic             supS2;
        logic             rstS1;
        logic             rstS2;
        logic             forceS1;
        logic             forceS2;
        logic             mainsS1;
        logic             mainsS2;
        logic             csS1;
        logic             csS2;
        logic             csPrev;
        logic [3:0]       lastCnt;
        logic [WIDTH-1:0] ctrlReg;
        logic [WIDTH-1:0] drivers;
        slo_sup_t         sup;
        logic [31:0]      supCnt;
        logic             rstOe;
        logic [31:0]      filtCnt;
        logic             zc;
    } slo_dev_state_t;

    slo_dev_state_t st;
    slo_dev_state_t next_st;

    logic             inReset;
    logic             csRise;
    logic [3:0]       frameBits;
    logic [WIDTH-1:0] drv;

    // ================================================================
    // link shift register, msb first while select is low
    always_comb begin
        next_lnk = lnk;
        if (!link.csN) begin
            next_lnk.shift  = {lnk.shift[WIDTH-2:0], link.mosi};
            next_lnk.bitCnt = lnk.bitCnt + 4'h1;
        end
    end

    always_ff @(posedge link.sclk or negedge arst_n) begin
        if (!arst_n) begin
            lnk <= '0;
        end else begin
            lnk <= next_lnk;
        end
    end

    // ================================================================
    // reference domain next state
    always_comb begin
        next_st = st;

        // input synchronisers
        next_st.supS1   = supplyGood;
        next_st.supS2   = st.supS1;
        next_st.rstS1   = link.rstN;
        next_st.rstS2   = st.rstS1;
        next_st.forceS1 = firstDriverForceOn;
        next_st.forceS2 = st.forceS1;
        next_st.mainsS1 = mainsSenseIn;
        next_st.mainsS2 = st.mainsS1;
        next_st.csS1    = link.csN;
        next_st.csS2    = st.csS1;
        next_st.csPrev  = st.csS2;

        // reset supervisor
        case (st.sup)
            SLO_SUP_HOLD: begin
                next_st.rstOe = 1'b1;
                if (st.supS2) begin
                    if (st.supCnt >= 32'(RESET_DELAY - 1)) begin
                        next_st.sup    = SLO_SUP_RUN;
                        next_st.rstOe  = 1'b0;
                        next_st.supCnt = '0;
                    end else begin
                        next_st.supCnt = st.supCnt + 32'h1;
                    end
                end else begin
                    next_st.supCnt = '0;
                end
            end
            SLO_SUP_RUN: begin
                next_st.rstOe = 1'b0;
                if (!st.supS2) begin
                    if (st.supCnt >= 32'(DEGLITCH - 1)) begin
                        next_st.sup    = SLO_SUP_HOLD;
                        next_st.rstOe  = 1'b1;
                        next_st.supCnt = '0;
                    end else begin
                        next_st.supCnt = st.supCnt + 32'h1;
                    end
                end else begin
                    next_st.supCnt = '0;
                end
            end
            default: begin
                next_st.sup    = SLO_SUP_HOLD;
                next_st.rstOe  = 1'b1;
                next_st.supCnt = '0;
            end
        endcase

        // frame load on select rising, only frames whose bit count modulo 16 is eight
        csRise    = st.csS2 & ~st.csPrev;
        frameBits = lnk.bitCnt - st.lastCnt;
        inReset   = st.rstOe | ~st.rstS2;
        if (csRise) begin
            next_st.lastCnt = lnk.bitCnt;
            if (frameBits == 4'(FRAME_BITS) && !inReset) begin
                next_st.ctrlReg = lnk.shift;
            end
        end
        if (inReset) begin
            next_st.ctrlReg = CTRL_RESET;
        end

        // driver outputs, bit n drives driver n
        drv    = st.ctrlReg;
        drv[0] = st.ctrlReg[0] | st.forceS2;
        if (inReset) begin
            drv = '0;
        end
        next_st.drivers = drv;

        // sync output follows mains sense only after a stable interval
        if (st.mainsS2 == st.zc) begin
            next_st.filtCnt = '0;
        end else if (st.filtCnt >= 32'(SYNC_FILTER - 1)) begin
            next_st.zc      = st.mainsS2;
            next_st.filtCnt = '0;
        end else begin
            next_st.filtCnt = st.filtCnt + 32'h1;
        end
    end

    // ================================================================
    // reference domain registers
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st         <= '0;
            st.sup     <= SLO_SUP_HOLD;
            st.rstOe   <= 1'b1;
            st.csS1    <= 1'b1;
            st.csS2    <= 1'b1;
            st.csPrev  <= 1'b1;
            st.ctrlReg <= CTRL_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ================================================================
    // outputs
    assign link.rstOe       = st.rstOe;
    assign lowSideDrivers   = st.drivers;
    assign zeroCrossSyncOut = st.zc;

endmodule : slo_device

// ==== hw/slo_host.sv ====
// host end: waits for reset release, sends eight-bit frames msb first
`timescale 1ns/100ps

module slo_host
    import slo_pkg::*;
#(
    parameter int WIDTH     = FRAME_BITS,
    parameter int HALF_CYC  = SCLK_HALF_CYC,
    parameter int GAP_CYC   = FRAME_GAP_CYC
) (
    input  wire logic             ref_clk,
    input  wire logic             arst_n,
    slo_link_if.host              link,
    input  wire logic             writeValid,
    input  wire logic [WIDTH-1:0] writeData,
    output logic                  writeReady,
    output logic                  deviceReady
);

    // ================================================================
    // state
    typedef struct packed {
        slo_host_t        st;
        logic             rstS1;
        logic             rstS2;
        logic [WIDTH-1:0] shift;
        logic [3:0]       bitCnt;
        logic [7:0]       divCnt;
        logic             csN;
        logic             sclk;
        logic             mosi;
        logic             ready;
    } slo_host_state_t;

    slo_host_state_t h;
    slo_host_state_t next_h;

    // ================================================================
    // next state
    always_comb begin
        next_h       = h;
        next_h.rstS1 = link.rstN;
        next_h.rstS2 = h.rstS1;
        case (h.st)
            SLO_HOST_IDLE: begin
                next_h.ready = h.rstS2;
                if (writeValid && h.ready && h.rstS2) begin
                    next_h.ready  = 1'b0;
                    next_h.shift  = writeData;
                    next_h.mosi   = writeData[WIDTH-1];
                    next_h.csN    = 1'b0;
                    next_h.bitCnt = '0;
                    next_h.divCnt = '0;
                    next_h.st     = SLO_HOST_LOW;
                end
            end
            SLO_HOST_LOW: begin
                if (h.divCnt == 8'(HALF_CYC - 1)) begin
                    next_h.sclk   = 1'b1;
                    next_h.divCnt = '0;
                    next_h.st     = SLO_HOST_HIGH;
                end else begin
                    next_h.divCnt = h.divCnt + 8'h1;
                end
            end
            SLO_HOST_HIGH: begin
                if (h.divCnt == 8'(HALF_CYC - 1)) begin
                    next_h.sclk   = 1'b0;
                    next_h.divCnt = '0;
                    next_h.bitCnt = h.bitCnt + 4'h1;
                    next_h.shift  = {h.shift[WIDTH-2:0], 1'b0};
                    if (h.bitCnt == 4'(WIDTH - 1)) begin
                        next_h.csN = 1'b1;
                        next_h.st  = SLO_HOST_GAP;
                    end else begin
                        next_h.mosi = h.shift[WIDTH-2];
                        next_h.st   = SLO_HOST_LOW;
                    end
                end else begin
                    next_h.divCnt = h.divCnt + 8'h1;
                end
            end
            SLO_HOST_GAP: begin
                if (h.divCnt == 8'(GAP_CYC - 1)) begin
                    next_h.divCnt = '0;
                    next_h.ready  = h.rstS2;
                    next_h.st     = SLO_HOST_IDLE;
                end else begin
                    next_h.divCnt = h.divCnt + 8'h1;
                end
            end
            default: begin
                next_h.st = SLO_HOST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            h     <= '0;
            h.st  <= SLO_HOST_IDLE;
            h.csN <= 1'b1;
        end else begin
            h <= next_h;
        end
    end

    // ================================================================
    // outputs
    assign link.csN       = h.csN;
    assign link.sclk      = h.sclk;
    assign link.mosi      = h.mosi;
    assign link.hostRstOe = 1'b0;
    assign writeReady     = h.ready;
    assign deviceReady    = h.rstS2;

endmodule : slo_host

// ==== test/slo_link_chk.sv ====
// concurrent checks on the host-device link and the device outputs
`timescale 1ns/100ps

module slo_link_chk
    import slo_pkg::*;
#(
    parameter int RESET_DELAY = RESET_DELAY_CYC,
    parameter int DEGLITCH    = DEGLITCH_CYC,
    parameter int SYNC_FILTER = SYNC_FILTER_CYC
) (
    input wire logic       ref_clk,
    input wire logic       arst_n,
    input wire logic       csN,
    input wire logic       sclk,
    input wire logic       mosi,
    input wire logic       rstOe,
    input wire logic       rstN,
    input wire logic       supplyGood,
    input wire logic       firstDriverForceOn,
    input wire logic       mainsSenseIn,
    input wire logic [7:0] lowSideDrivers,
    input wire logic       zeroCrossSyncOut
);
    int goodCnt;
    int badCnt;
    int mainsCnt;
    int bitCnt;
    int sinceCs;

    // ==========================================================
    // helper counters
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            goodCnt  <= 0;
            badCnt   <= 0;
            mainsCnt <= 0;
            bitCnt   <= 0;
            sinceCs  <= 15;
        end else begin
            goodCnt  <= supplyGood ? goodCnt + 1 : 0;
            badCnt   <= supplyGood ? 0 : badCnt + 1;
            mainsCnt <= $changed(mainsSenseIn) ? 0 : mainsCnt + 1;
            bitCnt   <= $fell(csN) ? 0 : bitCnt + int'(!csN && $rose(sclk));
            sinceCs  <= $rose(csN) ? 0 : sinceCs + int'(sinceCs < 15);
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    sclk_idle_a: assert property (csN |-> !sclk)
        else $error("link clock active while select high");
    mosi_hold_a: assert property (sclk && $past(sclk) |-> $stable(mosi))
        else $error("data moved while link clock high");
    frame_bits_a: assert property ($rose(csN) |-> bitCnt == FRAME_BITS)
        else $error("frame without eight clock rises");
    host_wait_a: assert property ($fell(csN) |-> rstN && $past(rstN, 3))
        else $error("frame started during reset");
    release_delay_a: assert property ($fell(rstOe) |->
        goodCnt >= RESET_DELAY && goodCnt <= RESET_DELAY + 6)
        else $error("reset released at wrong time");
    fault_deglitch_a: assert property ($rose(rstOe) |->
        badCnt >= DEGLITCH && badCnt <= DEGLITCH + 6)
        else $error("reset asserted at wrong time");
    reset_clear_a: assert property (rstOe ##1 rstOe |-> lowSideDrivers == 8'h00)
        else $error("drivers on during reset");
    force_on_a: assert property ((firstDriverForceOn && !rstOe) [*5] |-> lowSideDrivers[0])
        else $error("first driver not forced on");
    load_time_a: assert property ($changed(lowSideDrivers[7:1]) &&
        !rstOe && !$past(rstOe) |-> sinceCs inside {[2:6]})
        else $error("drivers changed outside frame load");
    sync_filter_a: assert property ($changed(zeroCrossSyncOut) |->
        zeroCrossSyncOut == mainsSenseIn && mainsCnt >= SYNC_FILTER)
        else $error("sync output passed a short pulse");
endmodule : slo_link_chk

// ==== test/serial_low_side_output_control_tb.sv ====
// testbench: host and device back to back, plus a bench-driven second device
`timescale 1ns/100ps

module serial_low_side_output_control_tb;
    import slo_pkg::*;

    localparam int RD = 20;
    localparam int DG = 10;
    localparam int SF = 5;
    localparam logic [31:0] CORNER = 32'h8001FF00;

    logic       ref_clk;
    logic       arst_n;
    logic       supplyGood;
    logic       firstDriverForceOn;
    logic       mainsSenseIn;
    logic       writeValid;
    logic [7:0] writeData;
    logic       writeReady;
    logic       deviceReady;
    logic [7:0] lowSideDrivers;
    logic [7:0] drivers2;
    logic       zeroCrossSyncOut;
    logic [7:0] d;
    int         n;
    int         lng;
    int         nFail;
    int         numChecks;

    slo_link_if link ();
    slo_link_if link2 ();

    slo_host slo_host_i (.ref_clk, .arst_n, .link(link.host), .writeValid, .writeData,
        .writeReady, .deviceReady);
    slo_device #(.RESET_DELAY(RD), .DEGLITCH(DG), .SYNC_FILTER(SF)) slo_device_i (
        .ref_clk, .arst_n, .link(link.device), .supplyGood, .firstDriverForceOn,
        .mainsSenseIn, .lowSideDrivers, .zeroCrossSyncOut);
    slo_device #(.RESET_DELAY(RD), .DEGLITCH(DG), .SYNC_FILTER(SF)) slo_device_i2 (
        .ref_clk, .arst_n, .link(link2.device), .supplyGood, .firstDriverForceOn,
        .mainsSenseIn, .lowSideDrivers(drivers2), .zeroCrossSyncOut());
    slo_link_chk #(.RESET_DELAY(RD), .DEGLITCH(DG), .SYNC_FILTER(SF)) slo_link_chk_i (
        .ref_clk, .arst_n, .csN(link.csN), .sclk(link.sclk), .mosi(link.mosi),
        .rstOe(link.rstOe), .rstN(link.rstN), .supplyGood, .firstDriverForceOn,
        .mainsSenseIn, .lowSideDrivers, .zeroCrossSyncOut);

    // ==========================================================
    // helpers
    function automatic logic [7:0] drvExp(input logic [7:0] v, input logic f);
        drvExp = v | {7'h00, f};
    endfunction : drvExp

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        numChecks++;
        if (seen !== exp) begin
            nFail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic waitReady();
        int k;
        for (k = 0; k < 2000 && writeReady !== 1'b1; k++) @(negedge ref_clk);
        chk("writeReady", {7'h00, writeReady}, 8'h01);
    endtask : waitReady

    task automatic send(input logic [7:0] v);
        waitReady();
        @(posedge ref_clk) writeValid <= 1'b1;
        writeData <= v;
        @(posedge ref_clk) writeValid <= 1'b0;
        repeat (2) @(negedge ref_clk);
        waitReady();
        repeat (4) @(negedge ref_clk);
    endtask : send

    // frame of up to sixteen bits on the second link, clocked at 64 ns
    task automatic frame2(input logic [15:0] v, input int nb);
        link2.csN = 1'b0;
        #37;
        for (int i = nb - 1; i >= 0; i--) begin
            link2.mosi = v[i];
            #32 link2.sclk = 1'b1;
            #32 link2.sclk = 1'b0;
        end
        #21 link2.csN = 1'b1;
        link2.mosi = ~link2.mosi;
        #150;
    endtask : frame2

    task automatic final_report();
        $display("checks %0d mismatches %0d", numChecks, nFail);
        if (nFail == 0 && numChecks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    // ==========================================================
    // clock and watchdog
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    initial begin
        #400000;
        nFail++;
        $display("mismatch watchdog expected done seen timeout");
        final_report();
    end

    // ==========================================================
    // tests
    initial begin
        nFail = 0;
        numChecks = 0;
        arst_n = 1'b1;
        supplyGood = 1'b0;
        firstDriverForceOn = 1'b0;
        mainsSenseIn = 1'b0;
        writeValid = 1'b0;
        writeData = 8'h00;
        link2.csN = 1'b1;
        link2.sclk = 1'b0;
        link2.mosi = 1'b0;
        link2.hostRstOe = 1'b0;
        #1 arst_n = 1'b0;
        void'($urandom(32'hEAA8C981));
        repeat (8) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (4) @(negedge ref_clk);
        chk("drivers", lowSideDrivers, 8'h00);
        chk("rstN", {7'h00, link.rstN}, 8'h00);
        @(posedge ref_clk) supplyGood <= 1'b1;
        repeat (RD - 2) @(negedge ref_clk);
        chk("rstN", {7'h00, link.rstN}, 8'h00);
        waitReady();
        chk("rstN", {7'h00, link.rstN}, 8'h01);
        chk("deviceReady", {7'h00, deviceReady}, 8'h01);
        $display("test reset done");

        for (int i = 0; i < 24; i++) begin
            d = (i < 4) ? CORNER[31-8*i -: 8] : 8'($urandom());
            send(d);
            chk("drivers", lowSideDrivers, drvExp(d, 1'b0));
        end
        $display("test frames done");

        @(posedge ref_clk) firstDriverForceOn <= 1'b1;
        send(8'hA4);
        chk("drivers", lowSideDrivers, drvExp(8'hA4, 1'b1));
        @(posedge ref_clk) firstDriverForceOn <= 1'b0;
        repeat (6) @(negedge ref_clk);
        chk("drivers", lowSideDrivers, drvExp(8'hA4, 1'b0));
        $display("test force done");

        @(posedge ref_clk) supplyGood <= 1'b0;
        repeat (DG - 3) @(posedge ref_clk);
        supplyGood <= 1'b1;
        repeat (6) @(negedge ref_clk);
        chk("rstN", {7'h00, link.rstN}, 8'h01);
        chk("drivers", lowSideDrivers, 8'hA4);
        @(posedge ref_clk) supplyGood <= 1'b0;
        repeat (DG + 6) @(negedge ref_clk);
        chk("rstN", {7'h00, link.rstN}, 8'h00);
        chk("drivers", lowSideDrivers, 8'h00);
        @(posedge ref_clk) supplyGood <= 1'b1;
        waitReady();
        chk("drivers", lowSideDrivers, 8'h00);
        send(8'h3C);
        chk("drivers", lowSideDrivers, 8'h3C);
        $display("test supply done");

        for (int i = 0; i < 16; i++) begin
            lng = $urandom() % 2;
            n = lng ? SF + 4 + $urandom() % 6 : 1 + $urandom() % (SF - 2);
            @(posedge ref_clk) mainsSenseIn <= ~mainsSenseIn;
            repeat (n) @(negedge ref_clk);
            chk("zeroCross", {7'h00, zeroCrossSyncOut},
                {7'h00, lng ? mainsSenseIn : ~mainsSenseIn});
            @(posedge ref_clk) mainsSenseIn <= ~mainsSenseIn;
            repeat (SF + 8) @(negedge ref_clk);
            chk("zeroCross", {7'h00, zeroCrossSyncOut}, {7'h00, mainsSenseIn});
        end
        $display("test sync done");

        frame2(16'h00C3, 8);
        chk("drivers2", drivers2, 8'hC3);
        frame2(16'h005A, 7);
        chk("drivers2", drivers2, 8'hC3);
        frame2(16'h01A5, 9);
        chk("drivers2", drivers2, 8'hC3);
        @(posedge ref_clk) link2.hostRstOe <= 1'b1;
        repeat (4) @(negedge ref_clk);
        chk("drivers2", drivers2, 8'h00);
        @(posedge ref_clk) link2.hostRstOe <= 1'b0;
        $display("test link2 done");
        final_report();
    end
endmodule : serial_low_side_output_control_tb
